// ### sdd_pkg.sv
package sdd_pkg;
	// ****************************************
	// Clock and timing base
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS  = 25;                            // Period of mclk
	localparam int unsigned TICK_US        = 1;                             // Sync integrator step
	localparam int unsigned TICK_CYC       = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned DELAY_BASE_US  = 205;                           // Delay for code zero
	localparam int unsigned DELAY_STEP_US  = 8;                             // Added per code step
	localparam int unsigned DELAY_MAX_US   = 261;                           // Delay for code seven
	localparam int unsigned DELAY_STEP_CYC = DELAY_STEP_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned SAMPLE_US      = 500;                           // Presence sample interval
	localparam int unsigned WINDOW_MS      = 6;                             // Presence detect window
	localparam int unsigned BIT_TIME_NS    = 8000;                          // One frame bit
	localparam int unsigned BIT_CYC        = BIT_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned DISCH_TIME_US  = 20;                            // Pull-down pulse length
	localparam int unsigned DISCH_CYC      = DISCH_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned SYNC_PULSE_US  = 10;                            // Host sync pulse width
	localparam int unsigned SYNC_PULSE_CYC = SYNC_PULSE_US * 1000 / CLK_PERIOD_NS;
	// ****************************************
	// Counts and frame shape
	// ****************************************
	localparam logic [2:0] SYNC_VALID_CNT = 3'h7;                          // Integrator level for valid
	localparam logic [2:0] AUTO_RUN_CNT   = 3'h4;                          // Consecutive presence samples
	localparam logic [4:0] FRAME_MIN_BITS = 5'h0B;
	localparam logic [4:0] FRAME_MAX_BITS = 5'h12;
	localparam logic [1:0] START_PATTERN  = 2'h1;                          // Start bits, polarity low
	// ****************************************
	// Host register map and fields
	// ****************************************
	localparam logic [3:0]  REG_CTRL     = 4'h0;
	localparam logic [3:0]  REG_STATUS   = 4'h4;
	localparam logic [3:0]  REG_CONFIG   = 4'h8;
	localparam logic [3:0]  REG_RXDATA   = 4'hC;
	localparam int unsigned CTRL_SYNC    = 0;
	localparam int unsigned ST_BUSY      = 0;
	localparam int unsigned ST_RXV       = 1;
	localparam int unsigned ST_CFGERR    = 2;
	localparam int unsigned ST_REFUSED   = 3;
	localparam int unsigned CFG_A_FIXB   = 0;
	localparam int unsigned CFG_A_DIS    = 1;
	localparam int unsigned CFG_B_FIXB   = 2;
	localparam int unsigned CFG_B_DIS    = 3;
	localparam int unsigned CFG_AUTO     = 4;
	localparam int unsigned CFG_PARALLEL = 5;
	localparam int unsigned CFG_CODE_LSB = 8;
	localparam int unsigned CFG_LEN_LSB  = 16;
	localparam int unsigned RX_CNT_LSB   = 24;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
endpackage

// ### sdd_bus_if.sv
`timescale 1ns/1ps
interface sdd_bus_if;
	// Host to device: bus voltage comparator states
	logic sync_above;
	logic sync_below;
	// Device to host: frame line and bus currents
	logic tx_active;
	logic tx_bit;
	logic signal_pulldown_current;
	logic presence_detect_current;
	modport device (
		input  sync_above,
		input  sync_below,
		output tx_active,
		output tx_bit,
		output signal_pulldown_current,
		output presence_detect_current
	);
	modport host (
		output sync_above,
		output sync_below,
		input  tx_active,
		input  tx_bit,
		input  signal_pulldown_current,
		input  presence_detect_current
	);
endinterface

// ### sdd_device.sv
//
// Contract
// R1 - Delay 205us plus 8us per code
// R2 - Slot A frame fits code bit limit
// R3 - Prefer delay above minimum for frame
// R4 - Fixed bit set: delayed, slot B
// R5 - Exactly one device has fixed bit
// R6 - Pull-down only slot A with discharge
// R7 - Never discharge on slot B device
// R8 - Auto enable: detect current 6ms
// R9 - Downstream current seen: slot B delayed
// R10 - Sample 500us, four consecutive needed
// R11 - No downstream current: slot A, undelayed
// R12 - No sync during blanking interval
// R13 - Parallel wiring uses fixed mode only
// R14 - Series wiring: fixed or auto mode
// R15 - Two start bits, polarity dependent
// R16 - One idle bit after frame
// R17 - Up-down integrator, valid after seven
// R18 - Discharge only with sync enabled
// R19 - No frame without valid sync
// R20 - Frame length 11 to 18 bits
// R21 - Auto slot latched until reset
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module sdd_device #(
	parameter int unsigned DELAY_BASE_CYC = sdd_pkg::DELAY_BASE_US * 1000 / sdd_pkg::CLK_PERIOD_NS,
	parameter int unsigned SAMPLE_CYC     = sdd_pkg::SAMPLE_US * 1000 / sdd_pkg::CLK_PERIOD_NS,
	parameter int unsigned WINDOW_CYC     = sdd_pkg::WINDOW_MS * 1000000 / sdd_pkg::CLK_PERIOD_NS
) (
	// Clock, reset, enable
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Bus side
	sdd_bus_if.device        bus,
	// Configuration bits
	input  wire logic        slot_delay_code_msb,
	input  wire logic        slot_delay_code_mid,
	input  wire logic        slot_delay_code_lsb,
	input  wire logic        fixed_slot_b_enable,
	input  wire logic        auto_slot_detect_enable,
	input  wire logic        bus_discharge_enable,
	input  wire logic        sync_pulse_enable,
	input  wire logic        manchester_polarity,
	// Downstream presence sense pin
	input  wire logic        chain_current_sense,
	// Frame content
	input  wire logic [15:0] frame_payload,
	input  wire logic [4:0]  frame_len,
	// Status
	output logic             slot_b,
	output logic             init_done,
	output logic             sync_valid
);
	// ****************************************
	// Types and helpers
	// ****************************************
	typedef enum logic [4:0] {
		ST_INIT  = 5'b00001,
		ST_IDLE  = 5'b00010,
		ST_DELAY = 5'b00100,
		ST_FRAME = 5'b01000,
		ST_STOP  = 5'b10000
	} sdd_dev_state_t;

	// Delay in cycles for a code
	function automatic logic [17:0] delay_cycles(input logic [2:0] code);
		delay_cycles = 18'(DELAY_BASE_CYC + code * sdd_pkg::DELAY_STEP_CYC - 1); // R1
	endfunction

	// Length clamped to legal frame range
	function automatic logic [4:0] clamp_len(input logic [4:0] len);
		if (len < sdd_pkg::FRAME_MIN_BITS) begin
			clamp_len = sdd_pkg::FRAME_MIN_BITS; // R20
		end else if (len > sdd_pkg::FRAME_MAX_BITS) begin
			clamp_len = sdd_pkg::FRAME_MAX_BITS; // R20
		end else begin
			clamp_len = len;
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	sdd_dev_state_t state_q;       // Control state
	logic [1:0]     above_s_q;     // Upper comparator synchroniser
	logic [1:0]     below_s_q;     // Lower comparator synchroniser
	logic [1:0]     sense_s_q;     // Presence sense synchroniser
	logic [5:0]     tick_q;        // 1 us prescaler
	logic [2:0]     sync_cnt_q;    // Up-down integrator
	logic [17:0]    tmr_q;         // Window, delay and bit timer
	logic [17:0]    samp_q;        // Presence sample timer
	logic [2:0]     run_q;         // Consecutive presence samples
	logic           found_q;       // Presence seen in window
	logic           auto_b_q;      // Latched auto slot
	logic [4:0]     bit_idx_q;     // Bit being sent
	logic [4:0]     len_q;         // Length of this frame
	logic [17:0]    shift_q;       // Frame bits, MSB first
	logic           tx_active_q;   // Frame on line
	logic [9:0]     disch_q;       // Pull-down pulse timer
	logic           pd_sig_q;      // Pull-down current on
	logic           pd_det_q;      // Detect current on
	logic           valid_q;       // Sync accepted pulse

	// ****************************************
	// Decode
	// ****************************************
	wire [2:0]  code      = {slot_delay_code_msb, slot_delay_code_mid, slot_delay_code_lsb};
	wire        tick      = (tick_q == 6'(sdd_pkg::TICK_CYC - 1));
	wire        above     = above_s_q[1];
	wire        below     = below_s_q[1];
	wire        tmr_zero  = (tmr_q == 18'h0_0000);
	wire        samp_now  = (samp_q == 18'(SAMPLE_CYC - 1));
	wire        use_b     = fixed_slot_b_enable | auto_b_q;                      // R4 R9
	wire        accept    = (state_q == ST_IDLE) & sync_pulse_enable & tick
	                        & (sync_cnt_q == sdd_pkg::SYNC_VALID_CNT);          // R17 R19
	wire        go_frame  = (accept & ~use_b) | ((state_q == ST_DELAY) & tmr_zero); // R11
	wire        last_bit  = (bit_idx_q == len_q - 5'h01);
	wire [1:0]  start_pat = sdd_pkg::START_PATTERN ^ {2{manchester_polarity}}; // R15
	wire        disch_on  = accept & ~use_b & bus_discharge_enable;              // R6 R18

	// ****************************************
	// Synchronisers for pins
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			above_s_q <= 2'h0;
			below_s_q <= 2'h0;
			sense_s_q <= 2'h0;
		end else if (ce) begin
			above_s_q <= {above_s_q[0], bus.sync_above};
			below_s_q <= {below_s_q[0], bus.sync_below};
			sense_s_q <= {sense_s_q[0], chain_current_sense};
		end
	end

	// ****************************************
	// Microsecond prescaler
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			tick_q <= 6'h00;
		end else if (ce) begin
			tick_q <= tick ? 6'h00 : tick_q + 6'h01;
		end
	end

	// ****************************************
	// Sync integrator, blanked outside idle
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync_cnt_q <= 3'h0;
		end else if (ce) begin
			if (state_q != ST_IDLE || accept) begin
				sync_cnt_q <= 3'h0;
			end else if (tick && above && sync_cnt_q != sdd_pkg::SYNC_VALID_CNT) begin
				sync_cnt_q <= sync_cnt_q + 3'h1; // R17
			end else if (tick && below && !above && sync_cnt_q != 3'h0) begin
				sync_cnt_q <= sync_cnt_q - 3'h1; // R17
			end
		end
	end

	// ****************************************
	// Presence detection window
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			samp_q   <= 18'h0_0000;
			run_q    <= 3'h0;
			found_q  <= 1'b0;
			auto_b_q <= 1'b0;
			pd_det_q <= 1'b0;
		end else if (ce) begin
			if (state_q == ST_INIT) begin
				pd_det_q <= auto_slot_detect_enable & ~tmr_zero;        // R8
				samp_q   <= samp_now ? 18'h0_0000 : samp_q + 18'h0_0001;
				if (samp_now) begin
					// Count consecutive samples with current flowing
					if (sense_s_q[1]) begin
						run_q <= (run_q == sdd_pkg::AUTO_RUN_CNT) ? run_q : run_q + 3'h1; // R10
						if (run_q == sdd_pkg::AUTO_RUN_CNT - 3'h1) begin
							found_q <= 1'b1;                        // R10
						end
					end else begin
						run_q <= 3'h0;                              // R10
					end
				end
				if (tmr_zero) begin
					auto_b_q <= auto_slot_detect_enable & found_q;  // R21
				end
			end else begin
				pd_det_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Main sequence: wait, delay, frame, stop
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q     <= ST_INIT;
			tmr_q       <= 18'(WINDOW_CYC - 1);
			bit_idx_q   <= 5'h00;
			len_q       <= sdd_pkg::FRAME_MIN_BITS;
			shift_q     <= 18'h0_0000;
			tx_active_q <= 1'b0;
			valid_q     <= 1'b0;
		end else if (ce) begin
			valid_q <= accept;
			case (state_q)
				ST_INIT: begin
					// Window skipped when auto detection is off
					if (tmr_zero || !auto_slot_detect_enable) begin // R8
						state_q <= ST_IDLE;
					end else begin
						tmr_q <= tmr_q - 18'h0_0001;
					end
				end
				ST_IDLE: begin
					if (accept) begin
						len_q   <= clamp_len(frame_len);
						shift_q <= {start_pat, frame_payload};           // R15
						if (use_b) begin
							state_q <= ST_DELAY;                         // R4 R9
							tmr_q   <= delay_cycles(code);               // R1
						end
					end
				end
				ST_DELAY: begin
					if (!tmr_zero) begin
						tmr_q <= tmr_q - 18'h0_0001;
					end
				end
				ST_FRAME: begin
					if (!tmr_zero) begin
						tmr_q <= tmr_q - 18'h0_0001;
					end else if (last_bit) begin
						state_q     <= ST_STOP;                          // R16
						tx_active_q <= 1'b0;
						tmr_q       <= 18'(sdd_pkg::BIT_CYC - 1);
					end else begin
						shift_q   <= {shift_q[16:0], 1'b0};
						bit_idx_q <= bit_idx_q + 5'h01;
						tmr_q     <= 18'(sdd_pkg::BIT_CYC - 1);
					end
				end
				ST_STOP: begin
					// Idle bit, then the detector is re-armed
					if (tmr_zero) begin
						state_q <= ST_IDLE;                              // R16
					end else begin
						tmr_q <= tmr_q - 18'h0_0001;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
			// Frame start overrides the branch above
			if (go_frame) begin
				state_q     <= ST_FRAME;                                 // R19
				tx_active_q <= 1'b1;
				bit_idx_q   <= 5'h00;
				tmr_q       <= 18'(sdd_pkg::BIT_CYC - 1);
			end
		end
	end

	// ****************************************
	// Discharge pull-down pulse, slot A only
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			pd_sig_q <= 1'b0;
			disch_q  <= 10'h000;
		end else if (ce) begin
			if (disch_on) begin
				pd_sig_q <= 1'b1;                                        // R6 R18
				disch_q  <= 10'(sdd_pkg::DISCH_CYC - 1);
			end else if (disch_q != 10'h000) begin
				disch_q <= disch_q - 10'h001;
			end else begin
				pd_sig_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign bus.tx_active               = tx_active_q;
	assign bus.tx_bit                  = shift_q[17] & tx_active_q;
	assign bus.signal_pulldown_current = pd_sig_q;
	assign bus.presence_detect_current = pd_det_q;
	assign slot_b                      = use_b;
	assign init_done                   = (state_q != ST_INIT);
	assign sync_valid                  = valid_q;
endmodule

// ### sdd_host.sv
`timescale 1ns/1ps
module sdd_host #(
	parameter int unsigned GUARD_CYC = sdd_pkg::SYNC_PULSE_CYC + 8 * sdd_pkg::TICK_CYC
	                                   + sdd_pkg::DELAY_MAX_US * 1000 / sdd_pkg::CLK_PERIOD_NS
	                                   + (32'(sdd_pkg::FRAME_MAX_BITS) + 1) * sdd_pkg::BIT_CYC
) (
	// Clock, reset, enable
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Bus side
	sdd_bus_if.host          bus,
	// Register port
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata
);
	// ****************************************
	// State
	// ****************************************
	logic [17:0] guard_q;      // Blanking guard timer
	logic [9:0]  pulse_q;      // Sync pulse timer
	logic        refused_q;    // Sticky: sync request refused
	logic [31:0] config_q;     // Planned bus configuration
	logic [1:0]  act_s_q;      // Frame line synchroniser
	logic [1:0]  bit_s_q;      // Frame bit synchroniser
	logic        act_d_q;      // Previous frame line level
	logic [8:0]  bt_q;         // Bit sample timer
	logic [17:0] rx_sh_q;      // Incoming bits
	logic [4:0]  rx_n_q;       // Incoming bit count
	logic [17:0] rx_data_q;    // Last frame bits
	logic [4:0]  rx_cnt_q;     // Last frame length
	logic        rxv_q;        // Sticky: frame received
	logic [31:0] rdata_q;      // Read data

	// ****************************************
	// Decode
	// ****************************************
	wire        wr_ctrl  = wr & (addr == sdd_pkg::REG_CTRL);
	wire        wr_cfg   = wr & (addr == sdd_pkg::REG_CONFIG);
	wire        rd_rx    = rd & (addr == sdd_pkg::REG_RXDATA);
	wire        rd_st    = rd & (addr == sdd_pkg::REG_STATUS);
	wire        busy     = (guard_q != 18'h0_0000);
	wire        sync_req = wr_ctrl & wdata[sdd_pkg::CTRL_SYNC];
	wire        fire     = sync_req & ~busy;
	wire [2:0]  code     = config_q[sdd_pkg::CFG_CODE_LSB +: 3];
	wire [4:0]  len_a    = config_q[sdd_pkg::CFG_LEN_LSB +: 5];
	wire        a_fixb   = config_q[sdd_pkg::CFG_A_FIXB];
	wire        b_fixb   = config_q[sdd_pkg::CFG_B_FIXB];
	wire        auto_md  = config_q[sdd_pkg::CFG_AUTO];
	wire        err_one  = ~auto_md & (a_fixb == b_fixb);                                  // R5 R14
	wire        err_dis  = (config_q[sdd_pkg::CFG_A_DIS] & a_fixb)
	                       | (config_q[sdd_pkg::CFG_B_DIS] & b_fixb);                      // R7
	wire        err_par  = config_q[sdd_pkg::CFG_PARALLEL] & auto_md;                      // R13
	wire        err_len  = len_a > (sdd_pkg::FRAME_MIN_BITS + 5'(code));                   // R2
	wire        cfg_err  = err_one | err_dis | err_par | err_len;
	wire        act      = act_s_q[1];
	wire        samp     = act & (bt_q == 9'h000);
	wire [31:0] status   = {28'h000_0000, refused_q, cfg_err, rxv_q, busy};
	wire [31:0] rx_word  = {3'h0, rx_cnt_q, 6'h00, rx_data_q};

	// ****************************************
	// Sync pulse and blanking guard
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			guard_q   <= 18'h0_0000;
			pulse_q   <= 10'h000;
			refused_q <= 1'b0;
		end else if (ce) begin
			if (fire) begin
				guard_q <= 18'(GUARD_CYC);                       // R12
				pulse_q <= 10'(sdd_pkg::SYNC_PULSE_CYC);
			end else begin
				guard_q <= busy ? guard_q - 18'h0_0001 : guard_q;
				pulse_q <= (pulse_q != 10'h000) ? pulse_q - 10'h001 : pulse_q;
			end
			// Refusal sets over the clearing read
			if (sync_req && busy) begin
				refused_q <= 1'b1;                               // R12
			end else if (rd_st) begin
				refused_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Configuration register
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			config_q <= sdd_pkg::CONFIG_RESET;
		end else if (ce && wr_cfg) begin
			config_q <= wdata;
		end
	end

	// ****************************************
	// Frame receiver, samples mid-bit
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			act_s_q   <= 2'h0;
			bit_s_q   <= 2'h0;
			act_d_q   <= 1'b0;
			bt_q      <= 9'h000;
			rx_sh_q   <= 18'h0_0000;
			rx_n_q    <= 5'h00;
			rx_data_q <= 18'h0_0000;
			rx_cnt_q  <= 5'h00;
			rxv_q     <= 1'b0;
		end else if (ce) begin
			act_s_q <= {act_s_q[0], bus.tx_active};
			bit_s_q <= {bit_s_q[0], bus.tx_bit};
			act_d_q <= act;
			if (act && !act_d_q) begin
				bt_q   <= 9'(sdd_pkg::BIT_CYC / 2 - 1);
				rx_n_q <= 5'h00;
				rx_sh_q <= 18'h0_0000;            // Drop bits of the last frame
			end else if (samp) begin
				bt_q    <= 9'(sdd_pkg::BIT_CYC - 1);
				rx_sh_q <= {rx_sh_q[16:0], bit_s_q[1]};
				rx_n_q  <= rx_n_q + 5'h01;
			end else if (act) begin
				bt_q <= bt_q - 9'h001;
			end
			if (!act && act_d_q) begin
				rx_data_q <= rx_sh_q;
				rx_cnt_q  <= rx_n_q;
			end
			// New frame sets over the clearing read
			if (!act && act_d_q) begin
				rxv_q <= 1'b1;
			end else if (rd_rx) begin
				rxv_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Read data, one cycle after the strobe
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (ce) begin
			case (addr)
				sdd_pkg::REG_STATUS: rdata_q <= rd ? status : 32'h0000_0000;
				sdd_pkg::REG_CONFIG: rdata_q <= rd ? config_q : 32'h0000_0000;
				sdd_pkg::REG_RXDATA: rdata_q <= rd ? rx_word : 32'h0000_0000;
				default:             rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign bus.sync_above = (pulse_q != 10'h000);
	assign bus.sync_below = (pulse_q == 10'h000);
	assign rdata          = rdata_q;
endmodule

// ### sdd_bus_sva.sv
`timescale 1ns/1ps
module sdd_bus_sva #(
	parameter int WIN = 240
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Bus signals
	input wire logic sync_above,
	input wire logic sync_below,
	input wire logic tx_active,
	input wire logic tx_bit,
	input wire logic signal_pulldown_current,
	input wire logic presence_detect_current
);
	// ****
	// Helper counters
	// ****
	localparam int WLIM = WIN + 8; // Window with slack
	logic [11:0] since_q;          // Cycles since sync high
	logic [8:0]  phase_q;          // Cycle within a bit
	logic [12:0] len_q;            // Cycles of the frame
	logic [9:0]  pd_n_q;           // Cycles of pull-down
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Count sync age, bit phase and frame length
	always_ff @(posedge mclk) begin
		since_q <= rst ? 12'hFFF : sync_above ? 12'h000 : since_q + 12'(since_q != 12'hFFF);
		phase_q <= (rst || !tx_active || phase_q == 9'h13F) ? 9'h000 : phase_q + 9'h001;
		len_q   <= (rst || !tx_active) ? 13'h0000 : len_q + 13'h0001;
		pd_n_q  <= (rst || !signal_pulldown_current) ? 10'h000 : pd_n_q + 10'h001;
	end
	// ****
	// Checks
	// ****
	chk_bit_idle: assert property (!tx_active |-> !tx_bit) else $error("bit outside frame");
	chk_sync_levels: assert property (sync_below == !sync_above) else $error("sync levels clash");
	chk_sync_first: assert property ($rose(tx_active) |-> since_q < 12'hBB8) else $error("frame without sync");
	chk_bit_grid: assert property (tx_active && $past(tx_active) && $changed(tx_bit) |-> phase_q == 9'h000) else $error("bit edge off grid");
	chk_frame_len: assert property ($fell(tx_active) |-> len_q >= 13'hDC0 && len_q <= 13'h1680 && len_q % 13'h140 == 13'h0) else $error("bad frame length");
	chk_pd_slot_a: assert property ($rose(signal_pulldown_current) |-> tx_active) else $error("pull-down outside slot A");
	chk_pd_width: assert property (pd_n_q <= 10'h32A
		&& (!$fell(signal_pulldown_current) || pd_n_q >= 10'h317)) else $error("pull-down width");
	chk_detect_win: assert property ($rose(presence_detect_current) |-> ##[1:WLIM] !presence_detect_current) else $error("detect current too long");
	chk_sync_quiet: assert property ($rose(sync_above) |-> !tx_active && !signal_pulldown_current) else $error("sync during blanking");
endmodule

// ### test_dual_slot_sync_delay_control.sv
`timescale 1ns/1ps
module test_dual_slot_sync_delay_control;
	// ****
	// Signals
	// ****
	logic        mclk, rst, ce, wr, rd;       // Clock, control, strobes
	logic [3:0]  addr;                        // Register address
	logic [31:0] wdata, rdata;                // Register data
	logic [2:0]  code;                        // Delay code
	logic        fixb, dis, auto_en, sync;    // Mode bits
	logic        pol, sense;                  // Polarity, chain sense
	logic [15:0] pay;                         // Payload
	logic [4:0]  flen;                        // Frame length
	logic        slot_b, init_done, sync_valid;
	int          errors = 0;
	int          checks_done = 0;
	sdd_bus_if bus ();
	sdd_device #(.DELAY_BASE_CYC(50), .SAMPLE_CYC(20), .WINDOW_CYC(240)) u_sdd_device (
		.mclk, .rst, .ce, .bus(bus.device), .slot_delay_code_msb(code[2]), .slot_delay_code_mid(code[1]),
		.slot_delay_code_lsb(code[0]), .fixed_slot_b_enable(fixb), .auto_slot_detect_enable(auto_en),
		.bus_discharge_enable(dis), .sync_pulse_enable(sync), .manchester_polarity(pol),
		.chain_current_sense(sense), .frame_payload(pay), .frame_len(flen), .slot_b, .init_done, .sync_valid);
	sdd_host #(.GUARD_CYC(7000)) u_sdd_host (.mclk, .rst, .ce, .bus(bus.host), .addr, .wdata, .wr, .rd, .rdata);
	sdd_bus_sva #(.WIN(240)) u_sdd_bus_sva (.mclk, .rst, .sync_above(bus.sync_above),
		.sync_below(bus.sync_below), .tx_active(bus.tx_active), .tx_bit(bus.tx_bit),
		.signal_pulldown_current(bus.signal_pulldown_current),
		.presence_detect_current(bus.presence_detect_current));
	// Clock at 40 MHz
	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	// ****
	// Helpers
	// ****
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Verdict and stop
	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// A wait that ran out ends the run
	task automatic bound(input logic ok);
		chk(ok, 1);
		if (!ok)
			finish_test;
	endtask
	// One write cycle
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge mclk);
		wr <= 0;
	endtask
	// One read cycle, data the cycle after
	task automatic rreg(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1;
		@(posedge mclk);
		rd <= 0;
		@(negedge mclk);
		d = rdata;
	endtask
	// Poll until the host is no longer busy
	task automatic drain;
		logic [31:0] st;
		int n;
		st = 32'h1;
		for (n = 0; n < 5000 && st[0] !== 1'b0; n++)
			rreg(4'h4, st);
		bound(n < 5000);
	endtask
	// Fire one sync and judge the whole answer
	task automatic frame(input logic b, input logic [2:0] c);
		logic [17:0] v;
		logic [31:0] r;
		int n;
		wreg(4'h0, 32'h1);
		v = {pol ? 2'h2 : 2'h1, pay};
		for (n = 0; n < 1000 && sync_valid !== 1'b1; n++)
			@(negedge mclk);
		bound(n < 1000);
		chk(bus.signal_pulldown_current, dis & !b);
		chk(slot_b, b);
		for (n = 0; n < 3000 && bus.tx_active !== 1'b1; n++)
			@(negedge mclk);
		chk(n, b ? 50 + c * 320 : 0);
		repeat (160) @(negedge mclk);
		for (int i = 0; i < flen; i++) begin
			chk(bus.tx_bit, v[17 - i]);
			repeat (320) @(negedge mclk);
		end
		chk(bus.tx_active, 0);
		drain;
		rreg(4'hC, r);
		chk(r, {3'h0, flen, 6'h00, v >> (18 - flen)});
	endtask
	// ****
	// Scenarios
	// ****
	// Reset value, readback, unmapped, config errors
	task automatic t_regs;
		logic [31:0] r;
		logic [31:0] cfg [5] = '{32'h000B0004, 32'h000B0000, 32'h000B000C, 32'h000B0034, 32'h000C0004};
		rreg(4'h8, r);
		chk(r, sdd_pkg::CONFIG_RESET);
		rreg(4'h2, r);
		chk(r, 0);
		for (int i = 0; i < 5; i++) begin
			wreg(4'h8, cfg[i]);
			rreg(4'h8, r);
			chk(r, cfg[i]);
			rreg(4'h4, r);
			chk(r[2], i != 0);
		end
		$display("done regs");
	endtask
	// Slot A, discharge on, longest frame
	task automatic t_slot_a;
		@(posedge mclk);
		{fixb, dis, pol, code} <= 6'h1B;
		flen <= 5'h12;
		frame(0, 3'h3);
		$display("done slot_a");
	endtask
	// Slot B over every code, discharge must stay off
	task automatic t_codes;
		@(posedge mclk);
		{fixb, dis, pol} <= 3'h6;
		flen <= 5'h0B;
		for (int c = 0; c < 8; c++) begin
			code <= 3'(c);
			frame(1, 3'(c));
		end
		$display("done codes");
	endtask
	// Sync disabled: no frame, no pull-down
	task automatic t_nosync;
		int n;
		logic [31:0] r;
		@(posedge mclk);
		{sync, fixb, dis} <= 3'h1;
		wreg(4'h0, 32'h1);
		wreg(4'h0, 32'h1);
		rreg(4'h4, r);
		chk(r[3], 1);
		for (n = 0; n < 1500 && bus.tx_active !== 1'b1 && bus.signal_pulldown_current !== 1'b1; n++)
			@(negedge mclk);
		chk(n, 1500);
		drain;
		@(posedge mclk);
		sync <= 1;
		$display("done nosync");
	endtask
	// Power-up detection, optionally with a broken sense run
	task automatic t_auto(input logic s, input logic tg);
		int n;
		@(posedge mclk);
		{auto_en, fixb, dis, code} <= 6'h2A;
		sense <= s;
		rst <= 1;
		repeat (8) @(posedge mclk);
		rst <= 0;
		repeat (3) @(negedge mclk);
		chk(bus.presence_detect_current, 1);
		for (n = 0; n < 400 && init_done !== 1'b1; n++) begin
			@(negedge mclk);
			if (tg)
				sense <= n[5];
		end
		bound(n < 400);
		chk(slot_b, s & !tg);
		chk(bus.presence_detect_current, 0);
		sense <= !s;
		repeat (100) @(negedge mclk);
		chk(slot_b, s & !tg);
		$display("done auto");
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		{rst, ce, sync} = 3'h7;
		{wr, rd, fixb, dis, auto_en, pol, sense} = 7'h00;
		{addr, wdata, code} = 39'h0;
		pay = 16'hA5C3;
		flen = 5'h0B;
		repeat (8) @(posedge mclk);
		rst <= 0;
		t_regs;
		t_slot_a;
		t_codes;
		t_nosync;
		t_auto(0, 0);
		t_auto(1, 1);
		t_auto(1, 0);
		frame(1, 3'h2);
		finish_test;
	end
endmodule
